// ---- src/smshc_static_mem_ctl.sv ----
// Purpose: Static memory access sequencer with programmable setup, pulse and hold
// Assumes: Requests arrive synchronous to clk; memory data input is synchronous
// Notes: Each strobe bit pair gives the first and second half of a clock period
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - Early read protocol ignores programmed strobe setup and hold lengths.
// - Changing to a bank with setup cycles skips the chip-select-change wait.
// - Float count at least setup count: setup cycles are dropped.
// - Setup count above float count: float cycles are dropped.
// - Read setup 1.5-7.5, hold 0-7, pulse 1.5-128.5 clocks.
// - Write setup 1.5-7.5, hold 0.5-7, pulse 1-128 clocks.
// - Nonzero chip select setup field selects display mode with shortened chip select.
// - Field value 0 is full chip select; 1-3 shorten both ends that much.
// - Display mode captures read data when chip select rises.
// - Eight configuration registers, each resetting to 0x00002000.
// - Seven-bit wait count sets write strobe pulse from 1 to 128 clocks.
// - Wait count reads as zero while waits are disabled.
// - Wait enable bit turns programmed standard waits off or on.
// - Bus stays occupied for the data float time after a read.
// - Bus width field picks 16 or 8 bits; byte type matters at 16.
// - Read protocol bit picks standard at 0, early at 1.
// - Setup n gives n plus half clocks; hold 0 gives write half clock.
module smshc_static_mem_ctl
    import smshc_pkg::*;
(
    input wire logic clk, // 10 MHz clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic hreadyout, // Slave ready out
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire smshc_pkg::smshc_memreq_t memReq, // External access request
    output logic memReqReady, // Request taken when high with valid
    output smshc_pkg::smshc_memrsp_t memRsp, // Access completion
    output smshc_pkg::smshc_pins_t memPins, // External memory pins
    input wire logic [15:0] memDataIn // Data from external memory
);
    import smshc_pkg::*;

    logic [31:0] cfg [NUM_CS];
    logic [31:0] cfgRead [NUM_CS];
    logic dataPhaseWrite;
    logic [2:0] dataPhaseIndex;

    smshc_state_t state;
    logic [2:0] curCs;
    logic curWrite;
    logic [9:0] setupH;
    logic [9:0] pulseH;
    logic [9:0] totalC;
    logic [9:0] captureC;
    logic [1:0] curCsSetup;
    logic [9:0] cyc;
    logic [4:0] gapCnt;
    logic [3:0] floatCnt;
    logic [2:0] lastCs;
    logic lastValid;
    logic lastWrite;

    // Address phase decode
    logic addrValid;
    logic addrMapped;
    logic [2:0] addrIndex;

    always_comb begin
        addrMapped = 1'b0;
        addrIndex = 3'h0;
        for (int i = 0; i < NUM_CS; i++) begin
            if (haddr[7:0] == CFG_OFFSET[i] && haddr[ADDR_DECODE_MSB:8] == '0) begin
                addrMapped = 1'b1;
                addrIndex = 3'(i);
            end
        end
    end

    assign addrValid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        for (int i = 0; i < NUM_CS; i++) begin
            cfgRead[i] = cfg[i];
            if (!cfg[i][WAIT_EN_BIT]) begin
                cfgRead[i][WAIT_CNT_LSB +: WAIT_CNT_W] = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dataPhaseWrite <= 1'b0;
            dataPhaseIndex <= 3'h0;
            hrdata <= 32'h0000_0000;
        end else begin
            dataPhaseWrite <= addrValid && addrMapped && hwrite;
            dataPhaseIndex <= addrIndex;
            if (addrValid && !hwrite) begin
                hrdata <= addrMapped ? cfgRead[addrIndex] : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CS; i++) begin
                cfg[i] <= CFG_RESET;
            end
        end else if (dataPhaseWrite) begin
            cfg[dataPhaseIndex] <= hwdata & CFG_WRITE_MASK;
        end
    end

    // Timing of the requested access
    logic [2:0] reqCs;
    logic [31:0] reqCfg;
    logic reqEarly;
    logic reqWaits;
    logic [6:0] reqWaitCnt;
    logic [2:0] reqSetup;
    logic [2:0] reqHold;
    logic [9:0] reqSetupH;
    logic [9:0] reqPulseH;
    logic [9:0] reqHoldH;
    logic [9:0] reqTotalH;
    logic [1:0] reqCsSetup;
    logic reqDiff;
    logic floatNeeded;
    logic dropSetup;
    logic [4:0] reqGap;

    assign reqCs = memReq.addr[REGION_LSB +: 3];
    assign reqCfg = cfg[reqCs];
    assign reqEarly = reqCfg[READ_PROT_BIT] && !memReq.write;
    assign reqWaits = reqCfg[WAIT_EN_BIT];
    assign reqWaitCnt = reqCfg[WAIT_CNT_LSB +: WAIT_CNT_W];
    assign reqSetup = reqCfg[READ_PROT_BIT] ? 3'h0 : reqCfg[SETUP_LSB +: 3];
    assign reqHold = reqCfg[READ_PROT_BIT] ? 3'h0 : reqCfg[HOLD_LSB +: 3];
    assign reqCsSetup = reqCfg[CS_SETUP_LSB +: 2];
    assign reqDiff = lastValid && (reqCs != lastCs);

    assign floatNeeded = (floatCnt != 4'h0) && (reqDiff || memReq.write);
    assign dropSetup = floatNeeded && (reqSetup != 3'h0) && ({1'b0, floatCnt} >= {2'b00, reqSetup});

    always_comb begin
        if (reqSetup != 3'h0 && !dropSetup) begin
            reqSetupH = 10'({reqSetup, 1'b1});
        end else if (reqEarly) begin
            reqSetupH = 10'h000;
        end else begin
            reqSetupH = 10'h001;
        end
        if (!reqWaits) begin
            reqPulseH = reqEarly ? 10'h002 : 10'h001;
        end else if (memReq.write) begin
            reqPulseH = 10'({reqWaitCnt, 1'b0}) + 10'h002;
        end else begin
            reqPulseH = 10'({reqWaitCnt, 1'b0}) + (reqEarly ? 10'h004 : 10'h003);
        end
        if (memReq.write && reqHold == 3'h0) begin
            reqHoldH = 10'h001;
        end else begin
            reqHoldH = 10'({reqHold, 1'b0});
        end
        reqTotalH = reqSetupH + reqPulseH + reqHoldH;
    end

    always_comb begin
        reqGap = 5'h00;
        if (floatNeeded && !(reqSetup != 3'h0 && !dropSetup)) begin
            reqGap = {1'b0, floatCnt};
        end else if (reqDiff && reqSetup == 3'h0 && !floatNeeded) begin
            reqGap = CS_CHANGE_WAIT;
        end
        if (lastValid && lastWrite && reqEarly) begin
            reqGap = reqGap + EARLY_READ_WAIT;
        end
    end

    assign memReqReady = (state == ST_IDLE);

    // Sequencer
    logic accessLast;
    assign accessLast = (state == ST_ACCESS) && (cyc == totalC - 10'h001);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cyc <= 10'h000;
            gapCnt <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    cyc <= 10'h000;
                    if (memReq.valid) begin
                        gapCnt <= reqGap;
                        state <= (reqGap != 5'h00) ? ST_GAP : ST_ACCESS;
                    end
                end
                ST_GAP: begin
                    gapCnt <= gapCnt - 5'h01;
                    if (gapCnt == 5'h01) begin
                        state <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    cyc <= cyc + 10'h001;
                    if (accessLast) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Access parameters latched at acceptance
    logic [MEM_ADDR_W-1:0] pinAddr;
    logic [15:0] pinDataOut;
    logic pinWidth16;
    logic pinByteSelect;
    logic [NUM_CS-1:0] pinCsN;
    logic [1:0] pinReadN;
    logic [1:0] pinWriteN;
    logic pinOe;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            curCs <= 3'h0;
            curWrite <= 1'b0;
            setupH <= 10'h000;
            pulseH <= 10'h000;
            totalC <= 10'h001;
            captureC <= 10'h000;
            curCsSetup <= 2'h0;
            pinAddr <= '0;
            pinDataOut <= 16'h0000;
            pinWidth16 <= 1'b1;
            pinByteSelect <= 1'b0;
        end else if (state == ST_IDLE && memReq.valid) begin
            curCs <= reqCs;
            curWrite <= memReq.write;
            setupH <= reqSetupH;
            pulseH <= reqPulseH;
            totalC <= (reqTotalH + 10'h001) >> 1;
            curCsSetup <= reqCsSetup;
            if (reqCsSetup != 2'h0) begin
                captureC <= ((reqTotalH + 10'h001) >> 1) - 10'h001 - 10'({8'h00, reqCsSetup});
            end else begin
                captureC <= (reqSetupH + reqPulseH - 10'h001) >> 1;
            end
            pinAddr <= memReq.addr[MEM_ADDR_W-1:0];
            pinDataOut <= memReq.wdata;
            pinWidth16 <= (reqCfg[WIDTH_LSB +: 2] == WIDTH_16);
            pinByteSelect <= (reqCfg[WIDTH_LSB +: 2] == WIDTH_16) && reqCfg[BYTE_TYPE_BIT];
        end
    end

    // Strobe halves of the current cycle
    logic [9:0] halfA;
    logic [9:0] halfB;
    logic strobeA;
    logic strobeB;
    logic csOn;

    assign halfA = {cyc[8:0], 1'b0};
    assign halfB = {cyc[8:0], 1'b1};
    assign strobeA = (halfA >= setupH) && (halfA < setupH + pulseH);
    assign strobeB = (halfB >= setupH) && (halfB < setupH + pulseH);
    assign csOn = (state == ST_ACCESS) && (cyc >= 10'({8'h00, curCsSetup}))
                  && (cyc + 10'({8'h00, curCsSetup}) < totalC);

    always_comb begin
        pinCsN = {NUM_CS{1'b1}};
        pinReadN = 2'h3;
        pinWriteN = 2'h3;
        pinOe = 1'b0;
        if (csOn) begin
            pinCsN[curCs] = 1'b0;
        end
        if (state == ST_ACCESS) begin
            pinOe = curWrite;
            if (curWrite) begin
                pinWriteN = {~strobeA, ~strobeB};
            end else begin
                pinReadN = {~strobeA, ~strobeB};
            end
        end
    end

    // One driver for the whole pin bundle
    assign memPins = '{chipSelectN: pinCsN, readStrobeN: pinReadN, writeStrobeN: pinWriteN,
                       addr: pinAddr, dataOut: pinDataOut, dataOe: pinOe,
                       busWidth16: pinWidth16, byteSelect: pinByteSelect};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            memRsp <= '0;
        end else begin
            memRsp.valid <= accessLast;
            if (state == ST_ACCESS && !curWrite && cyc == captureC) begin
                memRsp.rdata <= memDataIn;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            floatCnt <= 4'h0;
            lastCs <= 3'h0;
            lastValid <= 1'b0;
            lastWrite <= 1'b0;
        end else if (accessLast) begin
            floatCnt <= curWrite ? 4'h0 : cfg[curCs][FLOAT_LSB +: FLOAT_W];
            lastCs <= curCs;
            lastValid <= 1'b1;
            lastWrite <= curWrite;
        end else if (floatCnt != 4'h0) begin
            floatCnt <= floatCnt - 4'h1;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_RESET_CFG: assert property ($rose(rstn) |-> cfg[0] == CFG_RESET && cfg[7] == CFG_RESET)
        else $error("Config register not at reset value");
    AST_COUNT_HIDDEN: assert property (addrValid && !hwrite && addrMapped
        && !cfg[addrIndex][WAIT_EN_BIT] |=> hrdata[WAIT_CNT_LSB +: WAIT_CNT_W] == 7'h00)
        else $error("Wait count visible with waits disabled");
    AST_EARLY_NO_SETUP: assert property (state == ST_IDLE && memReq.valid && reqEarly
        |=> setupH == 10'h000)
        else $error("Early read got a setup length");
    AST_WRITE_PULSE: assert property (state == ST_IDLE && memReq.valid && memReq.write && reqWaits
        |=> pulseH == 10'({$past(reqWaitCnt), 1'b0}) + 10'h002)
        else $error("Write pulse not count plus one clocks");
    AST_DISPLAY_SHORT: assert property (state == ST_ACCESS && curCsSetup != 2'h0
        && cyc < 10'({8'h00, curCsSetup}) |-> memPins.chipSelectN == {NUM_CS{1'b1}})
        else $error("Chip select active in shortened lead");
    AST_FLOAT_DROPS_SETUP: assert property (state == ST_IDLE && memReq.valid && dropSetup
        |=> state == ST_GAP && setupH <= 10'h001)
        else $error("Setup kept under covering float");
    AST_SETUP_NO_GAP: assert property (state == ST_IDLE && memReq.valid && reqDiff
        && reqSetup != 3'h0 && !floatNeeded && !(lastWrite && reqEarly) |=> state == ST_ACCESS)
        else $error("Change wait inserted despite setup");
    AST_SETUP_DROPS_FLOAT: assert property (state == ST_IDLE && memReq.valid && floatNeeded
        && !dropSetup && reqSetup != 3'h0 && !(lastWrite && reqEarly) |=> state == ST_ACCESS)
        else $error("Float inserted with longer setup");
    AST_REGION_CS: assert property (state == ST_ACCESS && csOn
        |-> memPins.chipSelectN == ~(8'h01 << curCs))
        else $error("Wrong chip select driven");
    AST_FLOAT_ORDER: assert property (accessLast && !curWrite
        && cfg[curCs][FLOAT_LSB +: FLOAT_W] != 4'h0
        |=> floatCnt == $past(cfg[curCs][FLOAT_LSB +: FLOAT_W]))
        else $error("Float time not loaded after read");

    COV_DISPLAY_READ: cover property (state == ST_ACCESS && curCsSetup != 2'h0 && !curWrite);
    COV_FLOAT_GAP: cover property (state == ST_IDLE && memReq.valid && floatNeeded);
    COV_CS_CHANGE: cover property (state == ST_IDLE && memReq.valid && reqGap == CS_CHANGE_WAIT);
    COV_REG_WRITE: cover property (dataPhaseWrite);

endmodule

// ---- common/smshc_pkg.sv ----
// Purpose: Shared constants and types for the static memory timing block
// Assumes: One clock, AHB-Lite register access, 16-bit external data path
// Notes: Half-clock timing is carried as halves of a clock period
package smshc_pkg;

    localparam int NUM_CS = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_2000;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h7703_FFFF;
    localparam logic [7:0] CFG_OFFSET [NUM_CS] = '{8'h00, 8'h04, 8'h08, 8'h0C,
                                                  8'h10, 8'h14, 8'h18, 8'h1C};
    localparam int ADDR_DECODE_MSB = 11;

    // Field positions in a chip select configuration word
    localparam int WAIT_CNT_LSB = 0;
    localparam int WAIT_CNT_W = 7;
    localparam int WAIT_EN_BIT = 7;
    localparam int FLOAT_LSB = 8;
    localparam int FLOAT_W = 4;
    localparam int BYTE_TYPE_BIT = 12;
    localparam int WIDTH_LSB = 13;
    localparam int READ_PROT_BIT = 15;
    localparam int CS_SETUP_LSB = 16;
    localparam int SETUP_LSB = 24;
    localparam int HOLD_LSB = 28;

    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_8 = 2'h2;

    // External address layout: region select sits above the device address
    localparam int MEM_ADDR_W = 24;
    localparam int REGION_LSB = 24;
    localparam int REQ_ADDR_W = 27;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // Gap lengths between accesses in whole clocks
    localparam logic [4:0] CS_CHANGE_WAIT = 5'h01;
    localparam logic [4:0] EARLY_READ_WAIT = 5'h01;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_GAP = 3'b010,
        ST_ACCESS = 3'b100
    } smshc_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [REQ_ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } smshc_memreq_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } smshc_memrsp_t;

    typedef struct packed {
        logic [NUM_CS-1:0] chipSelectN;
        logic [1:0] readStrobeN;
        logic [1:0] writeStrobeN;
        logic [MEM_ADDR_W-1:0] addr;
        logic [15:0] dataOut;
        logic dataOe;
        logic busWidth16;
        logic byteSelect;
    } smshc_pins_t;

endpackage

// ---- tb/smshc_mem_model.sv ----
// Purpose: Behavioural static memory on the far side of the controller
// Assumes: Drives data only while selected with the read strobe active
// Notes: A released bus shows a pattern that toggles every cycle
`timescale 1ns/10ps
module smshc_mem_model
    import smshc_pkg::*;
(
    input wire logic clk, // Controller clock
    input wire smshc_pkg::smshc_pins_t pins, // Controller pins
    output logic [15:0] dataIn // Data towards controller
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h5A5A;
    logic sel;
    assign sel = pins.chipSelectN != 8'hFF;
    always @(posedge clk) begin
        last <= dataIn;
        if (sel && pins.writeStrobeN != 2'h3) begin
            mem[pins.addr[3:0]] <= pins.dataOut;
        end
    end
    always_comb begin
        if (sel && pins.readStrobeN != 2'h3) begin
            dataIn = mem[pins.addr[3:0]];
        end else begin
            dataIn = ~last;
        end
    end
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the static memory timing block
// Assumes: Register offsets are byte addresses; one memory model on the pins
// Notes: Strobe lengths are counted in half clocks, chip select lengths in whole clocks
`timescale 1ns/10ps
module tb;
    import smshc_pkg::*;
    localparam int LIMIT = 20000;
    logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, memReqReady, bw, bs, oe;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] memDataIn, rd;
    smshc_memreq_t memReq;
    smshc_memrsp_t memRsp;
    smshc_pins_t memPins;
    int badCount = 0;
    int nCompared = 0;
    int cycles = 0;
    int gap, setupH, pulseH, csCyc;
    assign hready = hreadyout;
    smshc_static_mem_ctl dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memReq(memReq),
        .memReqReady(memReqReady), .memRsp(memRsp), .memPins(memPins), .memDataIn(memDataIn));
    smshc_mem_model mem (.clk(clk), .pins(memPins), .dataIn(memDataIn));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task automatic finalReport();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        rv = hrdata;
    endtask
    function automatic logic [31:0] cfg(input int h, s, a, rp, wid, fl, we, wc);
        return {1'h0, h[2:0], 1'h0, s[2:0], 6'h00, a[1:0], rp[0], wid[1:0], 1'h0, fl[3:0],
                we[0], wc[6:0]};
    endfunction
    function automatic smshc_memreq_t mk(input logic wr, input int r, input logic [15:0] wd);
        return '{valid: 1'h1, write: wr, addr: {r[2:0], 24'h000003}, wdata: wd};
    endfunction
    // Runs the request held in memReq, placing nxt at the take edge
    task automatic memOp(input smshc_memreq_t nxt);
        smshc_memreq_t cur;
        logic [1:0] stb;
        gap = 0;
        setupH = 0;
        pulseH = 0;
        csCyc = 0;
        // Chained calls start on the low phase and must not skip a take edge
        if (clk) @(negedge clk);
        while (memReqReady !== 1'h1) @(negedge clk);
        cur = memReq;
        @(posedge clk);
        memReq <= nxt;
        do begin
            @(negedge clk);
            stb = cur.write ? memPins.writeStrobeN : memPins.readStrobeN;
            if (memPins.chipSelectN === ~(8'h01 << cur.addr[26:24])) begin
                if (csCyc == 0) begin
                    bw = memPins.busWidth16;
                    bs = memPins.byteSelect;
                    oe = memPins.dataOe;
                end
                csCyc++;
                for (int h = 1; h >= 0; h--) begin
                    if (stb[h] === 1'h0) pulseH++;
                    else if (pulseH == 0) setupH++;
                end
            end else if (csCyc == 0) begin
                gap++;
            end
        end while (memRsp.valid !== 1'h1);
        rd = memRsp.rdata;
    endtask
    task automatic op1(input logic wr, input int r, input logic [15:0] wd);
        @(posedge clk);
        memReq <= mk(wr, r, wd);
        memOp('0);
    endtask
    task automatic testRegs();
        for (int i = 0; i < NUM_CS; i++) begin
            ahb(1'h0, {24'h0, CFG_OFFSET[i]}, 32'h0);
            chk("reset value", 32'h0000_2000, rv);
        end
        ahb(1'h1, 32'h0C, 32'hFFFF_FFFF);
        ahb(1'h0, 32'h0C, 32'h0);
        chk("writable bits", 32'h7703_FFFF, rv);
        chk("response", 32'h0, {31'h0, hresp});
        ahb(1'h1, 32'h0C, 32'h0000_007F);
        ahb(1'h0, 32'h0C, 32'h0);
        chk("count with waits off", 32'h0, rv);
        ahb(1'h1, 32'h20, 32'h1234_5678);
        ahb(1'h0, 32'h20, 32'h0);
        chk("unmapped read", 32'h0, rv);
        ahb(1'h0, 32'h00, 32'h0);
        chk("neighbour untouched", 32'h0000_2000, rv);
        $display("test registers done");
    endtask
    task automatic testPulse();
        int ws[4] = '{0, 1, 1, 1};
        int nw[4] = '{0, 0, 5, 5};
        int dr[4] = '{0, 0, 0, 1};
        int p;
        for (int i = 0; i < 4; i++) begin
            ahb(1'h1, 32'h0, cfg(dr[i], 2 * dr[i], 0, dr[i], 1, 0, ws[i], nw[i]));
            p = ws[i] ? 2 * nw[i] + 2 : 1;
            op1(1'h1, 0, {12'hA5C, i[3:0]});
            chk("write pulse", p, pulseH);
            chk("write length", (p + 3) / 2, csCyc);
            chk("write data enable", 1, oe);
            p = ws[i] ? 2 * nw[i] + 3 + dr[i] : 1 + dr[i];
            op1(1'h0, 0, 16'h0);
            chk("read pulse", p, pulseH);
            chk("read setup", 1 - dr[i], setupH);
            chk("read length", (p + 2 - dr[i]) / 2, csCyc);
            chk("read gap", dr[i], gap);
            chk("read data enable", 0, oe);
            chk("read data", {12'hA5C, i[3:0]}, rd);
        end
        $display("test pulse done");
    endtask
    task automatic testSetup();
        int s, h, n;
        for (int i = 0; i < 2; i++) begin
            s = i ? 7 : 3;
            h = i ? 7 : 2;
            n = i ? 127 : 1;
            ahb(1'h1, 32'h4, cfg(h, s, 0, 0, 1, 0, 1, n));
            op1(1'h1, 1, {12'h3C0, i[3:0]});
            chk("write setup", 2 * s + 1, setupH);
            chk("write length", s + n + h + 2, csCyc);
            op1(1'h0, 1, 16'h0);
            chk("read setup", 2 * s + 1, setupH);
            chk("read pulse", 2 * n + 3, pulseH);
            chk("read length", s + n + h + 2, csCyc);
            chk("read data", {12'h3C0, i[3:0]}, rd);
        end
        $display("test setup done");
    endtask
    task automatic testGap();
        int t[6] = '{0, 0, 2, 2, 2, 2};
        int s[6] = '{0, 2, 1, 3, 0, 0};
        int r[6] = '{3, 3, 3, 3, 2, 2};
        int w[6] = '{0, 0, 0, 0, 0, 1};
        int e[6] = '{1, 0, 2, 0, 0, 2};
        for (int i = 0; i < 6; i++) begin
            ahb(1'h1, 32'h8, cfg(0, 0, 0, 0, 1, t[i], 1, 0));
            ahb(1'h1, 32'hC, cfg(1, s[i], 0, 0, 1, 0, 1, 0));
            @(posedge clk);
            memReq <= mk(1'h0, 2, 16'h0);
            memOp(mk(w[i][0], r[i], 16'h5AF0));
            memOp('0);
            chk("gap cycles", e[i], gap);
            chk("setup halves", (s[i] > t[i] && r[i] == 3) ? 2 * s[i] + 1 : 1, setupH);
        end
        $display("test gap done");
    endtask
    task automatic testDisplay();
        for (int a = 1; a < 4; a++) begin
            ahb(1'h1, 32'h10, cfg(0, 0, a, 0, 1, 0, 1, a + 2));
            op1(1'h1, 4, {12'hD1C, a[3:0]});
            chk("display write select", 4 - a, csCyc);
            op1(1'h0, 4, 16'h0);
            chk("display read select", 4 - a, csCyc);
            chk("display read data", {12'hD1C, a[3:0]}, rd);
        end
        $display("test display done");
    endtask
    task automatic testWidth();
        for (int i = 0; i < 3; i++) begin
            ahb(1'h1, 32'h14, cfg(0, 0, 0, 0, i ? i : 1, 0, 0, 0) | {19'h0, i == 0, 12'h0});
            op1(1'h1, 5, 16'h0);
            chk("bus width", i < 2, bw);
            chk("byte type", i == 0, bs);
        end
        $display("test width done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            badCount++;
            finalReport();
        end
    end
    initial begin
        rstn = 1'h0;
        hsel = 1'h0;
        haddr = '0;
        htrans = '0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = '0;
        memReq = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        testRegs();
        testPulse();
        testSetup();
        testGap();
        testDisplay();
        testWidth();
        finalReport();
    end
endmodule
